// *** afc_defs.svh ***
// Constants for the asynchronous FIFO host controller.
// Assumes a 125 MHz system clock and a FIFO device on plain pins.
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH

`define AFC_WORD_W        9
`define AFC_CLK_PERIOD_NS 8
// Least strobe low and high times, and reset low time, in ns.
`define AFC_STROBE_LOW_NS  16
`define AFC_STROBE_HIGH_NS 16
`define AFC_RESET_LOW_NS   40
`define AFC_RECOVER_NS     16
`define AFC_STROBE_LOW_CYC  ((`AFC_STROBE_LOW_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_STROBE_HIGH_CYC ((`AFC_STROBE_HIGH_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_RESET_LOW_CYC   ((`AFC_RESET_LOW_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_RECOVER_CYC     ((`AFC_RECOVER_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_CNT_W 4
`define AFC_CNT_ZERO 4'h0
`define AFC_WORD_ZERO 9'h000

`endif

// *** afc_pkg.sv ***
// Types for the asynchronous FIFO host controller.
// Assumes afc_defs.svh is on the include path.
`include "afc_defs.svh"
package afc_pkg;
	typedef logic [`AFC_WORD_W-1:0] afc_word_t;
	typedef logic [`AFC_CNT_W-1:0] afc_cnt_t;
	typedef enum logic [2:0] {
		AFC_IDLE    = 3'b000,
		AFC_CLEAR   = 3'b001,
		AFC_RECOVER = 3'b010,
		AFC_WR_LOW  = 3'b011,
		AFC_RD_LOW  = 3'b100,
		AFC_RT_LOW  = 3'b101,
		AFC_GAP     = 3'b110
	} afc_state_e;
endpackage

// *** afc_host.sv ***
// Host controller that drives one asynchronous FIFO device through its pins.
// Assumes device flags are synchronous to clk_i and the data buses in and out are separate.
//
// Summary of operation
// - Writer watches full, reader watches empty.
// - Lead device select low on first only.
// - Chain output feeds next chain input.
// - Composite flags combine empty and full; half-full is held low when chained.
// - Width expansion drives controls in parallel.
// - Writer toggles strobe only when not full.
// - Strobes high around master clear release.
`timescale 1ns/1ps
`include "afc_defs.svh"

module afc_host (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             clear_req_i,
	input  wire logic             write_req_i,
	input  wire afc_pkg::afc_word_t write_data_i,
	input  wire logic             read_req_i,
	input  wire logic             rewind_req_i,
	input  wire logic             single_mode_i,
	input  wire logic             lead_device_i,
	output logic                  write_done_o,
	output logic                  read_valid_o,
	output afc_pkg::afc_word_t    read_data_o,
	output logic                  busy_o,
	output logic                  empty_o,
	output logic                  full_o,
	output logic                  half_full_o,
	output logic                  master_clear_n_o,
	output logic                  write_strobe_n_o,
	output logic                  read_strobe_n_o,
	output logic                  rewind_read_n_o,
	output logic                  chain_in_n_o,
	output afc_pkg::afc_word_t    word_in_o,
	input  wire afc_pkg::afc_word_t word_out_i,
	input  wire logic             empty_indicator_n_i,
	input  wire logic             full_indicator_n_i,
	input  wire logic             half_full_indicator_n_i
);
	import afc_pkg::*;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	afc_state_e state_ff;
	afc_state_e nxt_state;
	afc_cnt_t   cnt_ff;
	afc_cnt_t   nxt_cnt;
	logic       wr_ff;
	logic       nxt_wr;
	logic       rd_ff;
	logic       nxt_rd;
	logic       rt_ff;
	logic       nxt_rt;
	logic       mc_ff;
	logic       nxt_mc;
	logic       wdone_ff;
	logic       nxt_wdone;
	logic       rvalid_ff;
	logic       nxt_rvalid;
	afc_word_t  wdata_ff;
	afc_word_t  nxt_wdata;
	afc_word_t  rdata_ff;
	afc_word_t  nxt_rdata;
	logic       chain_ff;
	logic       nxt_chain;
	logic       e_ff;
	logic       f_ff;
	logic       h_ff;
	logic       nxt_e;
	logic       nxt_f;
	logic       nxt_h;
	logic       busy_ff;
	logic       nxt_busy;

	always_comb begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_wr     = 1'b1;
		nxt_rd     = 1'b1;
		// The rewind pin doubles as lead select when chained.
		nxt_rt     = single_mode_i | ~lead_device_i;
		nxt_mc     = 1'b1;
		nxt_wdone  = 1'b0;
		nxt_rvalid = 1'b0;
		nxt_wdata  = wdata_ff;
		nxt_rdata  = rdata_ff;
		// Single mode grounds the chain input; chained mode hands it to the previous device.
		nxt_chain  = ~single_mode_i;
		unique case (state_ff)
			AFC_IDLE: begin
				nxt_cnt = `AFC_CNT_ZERO;
				if (clear_req_i) begin
					nxt_state = AFC_CLEAR;
					nxt_mc    = 1'b0;
				end else if (rewind_req_i && single_mode_i) begin
					nxt_state = AFC_RT_LOW;
					nxt_rt    = 1'b0;
				end else if (write_req_i && full_indicator_n_i) begin
					nxt_state = AFC_WR_LOW;
					nxt_wr    = 1'b0;
					nxt_wdata = write_data_i;
				end else if (read_req_i && empty_indicator_n_i) begin
					nxt_state = AFC_RD_LOW;
					nxt_rd    = 1'b0;
				end
			end
			AFC_CLEAR: begin
				// Strobes stay high through clear and its release.
				nxt_mc  = 1'b0;
				nxt_cnt = afc_cnt_t'(cnt_ff + 4'h1);
				if (cnt_ff == afc_cnt_t'(`AFC_RESET_LOW_CYC - 1)) begin
					nxt_mc    = 1'b1;
					nxt_cnt   = `AFC_CNT_ZERO;
					nxt_state = AFC_RECOVER;
				end
			end
			AFC_RECOVER: begin
				// Hold off until the flags settle after clear.
				nxt_cnt = afc_cnt_t'(cnt_ff + 4'h1);
				if (cnt_ff == afc_cnt_t'(`AFC_RECOVER_CYC - 1)) begin
					nxt_state = AFC_IDLE;
				end
			end
			AFC_WR_LOW: begin
				nxt_wr  = 1'b0;
				nxt_cnt = afc_cnt_t'(cnt_ff + 4'h1);
				if (cnt_ff == afc_cnt_t'(`AFC_STROBE_LOW_CYC - 1)) begin
					// Word is stored by the device on this rising edge.
					nxt_wr    = 1'b1;
					nxt_wdone = 1'b1;
					nxt_cnt   = `AFC_CNT_ZERO;
					nxt_state = AFC_GAP;
				end
			end
			AFC_RD_LOW: begin
				nxt_rd  = 1'b0;
				nxt_cnt = afc_cnt_t'(cnt_ff + 4'h1);
				if (cnt_ff == afc_cnt_t'(`AFC_STROBE_LOW_CYC - 1)) begin
					// Data is sampled while the strobe is still low.
					nxt_rdata  = word_out_i;
					nxt_rvalid = 1'b1;
					nxt_rd     = 1'b1;
					nxt_cnt    = `AFC_CNT_ZERO;
					nxt_state  = AFC_GAP;
				end
			end
			AFC_RT_LOW: begin
				nxt_rt  = 1'b0;
				nxt_cnt = afc_cnt_t'(cnt_ff + 4'h1);
				if (cnt_ff == afc_cnt_t'(`AFC_STROBE_LOW_CYC - 1)) begin
					nxt_rt    = 1'b1;
					nxt_cnt   = `AFC_CNT_ZERO;
					nxt_state = AFC_GAP;
				end
			end
			AFC_GAP: begin
				nxt_cnt = afc_cnt_t'(cnt_ff + 4'h1);
				if (cnt_ff == afc_cnt_t'(`AFC_STROBE_HIGH_CYC - 1)) begin
					nxt_state = AFC_IDLE;
				end
			end
			default: begin
				nxt_state = AFC_IDLE;
			end
		endcase
		nxt_busy = (nxt_state != AFC_IDLE);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff  <= AFC_CLEAR;
			cnt_ff    <= `AFC_CNT_ZERO;
			wr_ff     <= 1'b1;
			rd_ff     <= 1'b1;
			rt_ff     <= 1'b1;
			mc_ff     <= 1'b0;
			wdone_ff  <= 1'b0;
			rvalid_ff <= 1'b0;
			wdata_ff  <= `AFC_WORD_ZERO;
			rdata_ff  <= `AFC_WORD_ZERO;
			chain_ff  <= 1'b0;
			busy_ff   <= 1'b1;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			wr_ff     <= nxt_wr;
			rd_ff     <= nxt_rd;
			rt_ff     <= nxt_rt;
			mc_ff     <= nxt_mc;
			wdone_ff  <= nxt_wdone;
			rvalid_ff <= nxt_rvalid;
			wdata_ff  <= nxt_wdata;
			rdata_ff  <= nxt_rdata;
			chain_ff  <= nxt_chain;
			busy_ff   <= nxt_busy;
		end
	end

	// ------------------------------------------------------------
	// Flag capture
	// ------------------------------------------------------------
	// The pins carry one device's flags, or the composite of a chain.
	always_comb begin
		nxt_e = ~empty_indicator_n_i;
		nxt_f = ~full_indicator_n_i;
		nxt_h = single_mode_i & ~half_full_indicator_n_i;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			e_ff <= 1'b1;
			f_ff <= 1'b0;
			h_ff <= 1'b0;
		end else begin
			e_ff <= nxt_e;
			f_ff <= nxt_f;
			h_ff <= nxt_h;
		end
	end

	assign write_done_o     = wdone_ff;
	assign read_valid_o     = rvalid_ff;
	assign read_data_o      = rdata_ff;
	assign busy_o           = busy_ff;
	assign empty_o          = e_ff;
	assign full_o           = f_ff;
	assign half_full_o      = h_ff;
	assign master_clear_n_o = mc_ff;
	assign write_strobe_n_o = wr_ff;
	assign read_strobe_n_o  = rd_ff;
	assign rewind_read_n_o  = rt_ff;
	assign chain_in_n_o     = chain_ff;
	assign word_in_o        = wdata_ff;

endmodule

// *** afc_host_sva.sv ***
// Checker of afc_host pin sequencing.
// Assumes it is bound to afc_host.
`timescale 1ns/1ps
module afc_host_chk (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic master_clear_n_o,
	input wire logic write_strobe_n_o,
	input wire logic read_strobe_n_o,
	input wire logic rewind_read_n_o,
	input wire logic chain_in_n_o,
	input wire logic lead_device_i,
	input wire logic write_done_o,
	input wire logic read_valid_o,
	input wire logic empty_o,
	input wire logic full_o,
	input wire logic empty_indicator_n_i,
	input wire logic full_indicator_n_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_clear_strobes_high: assert property (!master_clear_n_o |-> write_strobe_n_o && read_strobe_n_o) else $error("strobe low in clear");
	a_write_pulse_len: assert property ($fell(write_strobe_n_o) |-> ##1 !write_strobe_n_o ##1 write_strobe_n_o && write_done_o) else $error("bad write pulse");
	a_write_needs_room: assert property ($fell(write_strobe_n_o) |-> $past(full_indicator_n_i)) else $error("write while full");
	a_read_needs_data: assert property ($fell(read_strobe_n_o) |-> $past(empty_indicator_n_i)) else $error("read while empty");
	a_read_valid_time: assert property ($fell(read_strobe_n_o) |-> ##2 read_valid_o && read_strobe_n_o) else $error("bad read pulse");
	a_rewind_single_only: assert property (
		chain_in_n_o && !$past(lead_device_i) |-> rewind_read_n_o)
		else $error("rewind when chained");
	a_empty_follows: assert property ($past(reset_n_i) |-> empty_o == !$past(empty_indicator_n_i)) else $error("empty lag");
	a_full_follows: assert property ($past(reset_n_i) |-> full_o == !$past(full_indicator_n_i)) else $error("full lag");
endmodule
bind afc_host afc_host_chk chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.master_clear_n_o(master_clear_n_o), .write_strobe_n_o(write_strobe_n_o),
	.read_strobe_n_o(read_strobe_n_o), .rewind_read_n_o(rewind_read_n_o),
	.chain_in_n_o(chain_in_n_o), .write_done_o(write_done_o), .read_valid_o(read_valid_o),
	.lead_device_i(lead_device_i),
	.empty_o(empty_o), .full_o(full_o), .empty_indicator_n_i(empty_indicator_n_i),
	.full_indicator_n_i(full_indicator_n_i));

// *** afc_fifo_model.sv ***
// Behavioural FIFO device driven by the host.
// Assumes strobes change only on the host clock.
`timescale 1ns/1ps
module afc_fifo_model #(parameter int DEPTH = 8) (
	input  wire logic               master_clear_n_i,
	input  wire logic               write_strobe_n_i,
	input  wire logic               read_strobe_n_i,
	input  wire logic               rewind_read_n_i,
	input  wire logic               chain_in_n_i,
	input  wire afc_pkg::afc_word_t word_in_i,
	output afc_pkg::afc_word_t      word_out_o,
	output logic                    empty_indicator_n_o,
	output logic                    full_indicator_n_o,
	output logic                    half_full_indicator_n_o
);
	afc_pkg::afc_word_t mem [DEPTH];
	afc_pkg::afc_word_t last = 9'h000;
	int wp, rp, cnt, wtot;
	always @(negedge master_clear_n_i) begin
		wp = 0;
		rp = 0;
		cnt = 0;
		wtot = 0;
	end
	always @(negedge rewind_read_n_i) if (!chain_in_n_i) begin
		rp = 0;
		cnt = wtot;
	end
	always @(posedge write_strobe_n_i) if (master_clear_n_i && cnt < DEPTH) begin
		mem[wp] = word_in_i;
		wp = (wp + 1) % DEPTH;
		cnt++;
		wtot++;
	end
	always @(posedge read_strobe_n_i) if (master_clear_n_i && cnt > 0) begin
		last = mem[rp];
		rp = (rp + 1) % DEPTH;
		cnt--;
	end
	assign word_out_o = read_strobe_n_i ? ~last : mem[rp];
	assign empty_indicator_n_o = (cnt != 0);
	assign full_indicator_n_o = (cnt != DEPTH);
	// Chained, the pin pulses low while the last location is written.
	assign half_full_indicator_n_o = chain_in_n_i ? !(!write_strobe_n_i && wp == DEPTH - 1)
		: (cnt <= DEPTH / 2);
endmodule

// *** afc_host_tb.sv ***
// Self-checking bench of afc_host with a device model.
// Assumes afc_pkg and afc_defs.svh are compiled first.
`timescale 1ns/1ps
module afc_host_tb;
	import afc_pkg::*;
	logic clk_i = 0, reset_n_i = 0, clear_req_i = 0, write_req_i = 0, read_req_i = 0;
	logic rewind_req_i = 0, single_mode_i = 1, lead_device_i = 0;
	afc_word_t write_data_i = 9'h000, read_data_o, word_in_o, word_out_i, got;
	logic write_done_o, read_valid_o, busy_o, empty_o, full_o, half_full_o, master_clear_n_o;
	logic write_strobe_n_o, read_strobe_n_o, rewind_read_n_o, chain_in_n_o;
	logic empty_indicator_n_i, full_indicator_n_i, half_full_indicator_n_i;
	int errors = 0, check_count = 0, cyc = 0;
	afc_word_t q[$];
	always #4 clk_i = ~clk_i;
	afc_host dut_u (.*);
	afc_fifo_model #(.DEPTH(8)) mdl_u (.master_clear_n_i(master_clear_n_o),
		.write_strobe_n_i(write_strobe_n_o), .read_strobe_n_i(read_strobe_n_o),
		.rewind_read_n_i(rewind_read_n_o), .chain_in_n_i(chain_in_n_o), .word_in_i(word_in_o),
		.word_out_o(word_out_i), .empty_indicator_n_o(empty_indicator_n_i),
		.full_indicator_n_o(full_indicator_n_i), .half_full_indicator_n_o(half_full_indicator_n_i));
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			close_out();
		end
	end
	task automatic idle;
		for (int i = 0; i < 40 && busy_o !== 1'b0; i++) begin
			@(posedge clk_i);
			#1;
			if (read_valid_o === 1'b1) got = read_data_o;
		end
	endtask
	task automatic op(input int k, input afc_word_t w, output logic took);
		idle();
		@(posedge clk_i);
		write_data_i <= w;
		case (k)
			0: clear_req_i <= 1;
			1: write_req_i <= 1;
			2: read_req_i <= 1;
			default: rewind_req_i <= 1;
		endcase
		@(posedge clk_i);
		{clear_req_i, write_req_i, read_req_i, rewind_req_i} <= 4'h0;
		#1;
		took = busy_o;
		idle();
	endtask
	initial begin
		logic t;
		afc_word_t w;
		w = $urandom(32'h2e21cf4e);
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1;
		idle();
		check(empty_o, 1);
		check(half_full_o, 0);
		check(chain_in_n_o, 0);
		op(2, 9'h000, t);
		check(t, 0);
		for (int i = 0; i < 8; i++) begin
			w = (i == 0) ? 9'h1ff : afc_word_t'($urandom);
			q.push_back(w);
			op(1, w, t);
			check(t, 1);
			check(half_full_o, i > 3);
		end
		check(full_o, 1);
		op(1, 9'h0aa, t);
		check(t, 0);
		for (int i = 0; i < 4; i++) begin
			op(2, 9'h000, t);
			check(got, q[i]);
			check(half_full_o, i < 3);
		end
		op(3, 9'h000, t);
		check(t, 1);
		op(2, 9'h000, t);
		check(got, q[0]);
		op(0, 9'h000, t);
		check(empty_o, 1);
		@(posedge clk_i);
		single_mode_i <= 0;
		lead_device_i <= 1;
		op(1, 9'h000, t);
		check(chain_in_n_o, 1);
		check(rewind_read_n_o, 0);
		@(posedge clk_i);
		lead_device_i <= 0;
		op(3, 9'h000, t);
		check(t, 0);
		check(rewind_read_n_o, 1);
		op(2, 9'h000, t);
		check(got, 9'h000);
		close_out();
	end
endmodule
